// ===== core/abtc_pkg.sv
package abtc_pkg;

   localparam int DATA_W = 8;
   localparam int REG_ADDR_W = 6;
   localparam int NUM_REGS = 64;
   localparam int BIT_SEL_W = 3;
   localparam int PC_W = 10;
   localparam int PC_HIGH_LSB = 8;
   localparam int OP_W = 3;
   localparam int STACK_DEPTH_DEF = 8;
   localparam logic [PC_W-1:0] PC_RESET = 10'h000;
   localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [PC_W-1:0] PC_STEP = 10'h001;

   // Instruction classes as decoded by fetch
   typedef enum logic [OP_W-1:0] {
      OP_NOP = 3'b000,
      OP_AND_IMMEDIATE = 3'b001,
      OP_BIT_SET = 3'b010,
      OP_SKIP_IF_CLEAR = 3'b011,
      OP_SKIP_IF_SET = 3'b100,
      OP_DIRECT_CALL = 3'b101,
      OP_INDIRECT_CALL = 3'b110,
      OP_LOAD_WORKING = 3'b111
   } abtc_op_e;

   // Execution phase
   typedef enum logic {
      PH_READY = 1'b0,
      PH_CALL_SECOND = 1'b1
   } abtc_phase_e;

   // One decoded instruction
   typedef struct packed {
      abtc_op_e op;
      logic [REG_ADDR_W-1:0] reg_addr;
      logic [BIT_SEL_W-1:0] bit_sel;
      logic [DATA_W-1:0] imm;
   } abtc_instr_s;

   // Register file write report
   typedef struct packed {
      logic we;
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } abtc_reg_wr_s;

   // Return stack push report
   typedef struct packed {
      logic we;
      logic [7:0] idx;
      logic [PC_W-1:0] data;
   } abtc_stack_wr_s;

endpackage : abtc_pkg

// ===== core/abtc_exec.sv
`timescale 1ns/1ns
module abtc_exec #(
   parameter int STACK_DEPTH = abtc_pkg::STACK_DEPTH_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire abtc_pkg::abtc_instr_s instr,
   input wire logic [abtc_pkg::DATA_W-1:0] pc_high_buffer,
   input wire logic [abtc_pkg::DATA_W-1:0] table_high_pointer,
   output logic instr_ready,
   output logic [abtc_pkg::DATA_W-1:0] working_register,
   output logic zero_flag,
   output logic [abtc_pkg::PC_W-1:0] pc,
   output logic [7:0] stack_pointer,
   output logic skip_pending,
   output abtc_pkg::abtc_reg_wr_s reg_wr,
   output abtc_pkg::abtc_stack_wr_s stack_wr
);
   import abtc_pkg::*;

   // Refuse stack depths the 8-bit pointer cannot serve
   if (STACK_DEPTH < 1 || STACK_DEPTH > 256) begin : g_bad_depth
      $error("STACK_DEPTH must be 1 to 256");
   end

   localparam logic [7:0] SP_LAST = 8'(STACK_DEPTH - 1);

   // Whole state of the execution unit
   typedef struct packed {
      abtc_phase_e phase;
      logic [DATA_W-1:0] wreg;
      logic zf;
      logic [PC_W-1:0] pc;
      logic [7:0] sp;
      logic skip;
      logic [NUM_REGS-1:0][DATA_W-1:0] regs;
      abtc_reg_wr_s rwr;
      abtc_stack_wr_s swr;
   } abtc_state_s;

   abtc_state_s st;
   abtc_state_s next_st;
   logic accept;
   logic sel_bit;
   logic [DATA_W-1:0] sel_reg;
   logic [DATA_W-1:0] and_result;
   logic [DATA_W-1:0] set_result;
   logic [PC_W-1:0] ret_addr;

   // Operand fetch and datapath results
   assign accept = instr_valid && (st.phase == PH_READY);
   assign sel_reg = st.regs[instr.reg_addr];
   assign sel_bit = sel_reg[instr.bit_sel];
   assign and_result = st.wreg & instr.imm;
   assign set_result = sel_reg | (8'h01 << instr.bit_sel);
   assign ret_addr = st.pc + PC_STEP;

   // Next-state logic
   always_comb begin
      next_st = st;
      next_st.rwr.we = 1'b0;
      next_st.swr.we = 1'b0;
      case (st.phase)
         PH_READY: begin
            if (accept) begin
               next_st.pc = ret_addr;
               if (st.skip) begin
                  next_st.skip = 1'b0;
               end else begin
                  case (instr.op)
                     OP_AND_IMMEDIATE: begin
                        next_st.wreg = and_result;
                        next_st.zf = (and_result == ZERO_BYTE);
                     end
                     OP_BIT_SET: begin
                        next_st.regs[instr.reg_addr] = set_result;
                        next_st.rwr.we = 1'b1;
                        next_st.rwr.addr = instr.reg_addr;
                        next_st.rwr.data = set_result;
                     end
                     OP_SKIP_IF_CLEAR: begin
                        next_st.skip = !sel_bit;
                     end
                     OP_SKIP_IF_SET: begin
                        next_st.skip = sel_bit;
                     end
                     OP_DIRECT_CALL, OP_INDIRECT_CALL: begin
                        next_st.swr.we = 1'b1;
                        next_st.swr.idx = st.sp;
                        next_st.swr.data = ret_addr;
                        next_st.sp = (st.sp == SP_LAST) ? 8'h00 : st.sp + 8'h01;
                        next_st.phase = PH_CALL_SECOND;
                        if (instr.op == OP_DIRECT_CALL) begin
                           next_st.pc = {pc_high_buffer[1:0], instr.imm};
                        end else begin
                           next_st.pc = {table_high_pointer[1:0], st.wreg};
                        end
                     end
                     OP_LOAD_WORKING: begin
                        next_st.wreg = instr.imm;
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         PH_CALL_SECOND: begin
            next_st.phase = PH_READY;
         end
         default: begin
            next_st.phase = PH_READY;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.phase <= PH_READY;
         st.wreg <= WREG_RESET;
         st.pc <= PC_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flip-flops
   assign instr_ready = (st.phase == PH_READY);
   assign working_register = st.wreg;
   assign zero_flag = st.zf;
   assign pc = st.pc;
   assign stack_pointer = st.sp;
   assign skip_pending = st.skip;
   assign reg_wr = st.rwr;
   assign stack_wr = st.swr;

endmodule : abtc_exec

// ===== tb/abtc_stack_model.sv
`timescale 1ns/1ns
module abtc_stack_model (
   input wire logic mclk,
   input wire abtc_pkg::abtc_stack_wr_s stack_wr
);
   import abtc_pkg::*;
   logic [PC_W-1:0] mem [256];
   // Return stack keeps each pushed address
   always_ff @(posedge mclk) if (stack_wr.we) mem[stack_wr.idx] <= stack_wr.data;
endmodule : abtc_stack_model

// ===== tb/abtc_exec_assertions.sv
`timescale 1ns/1ns
module abtc_exec_assertions (
   input wire logic mclk, input wire logic rst_n, input wire logic instr_valid,
   input wire abtc_pkg::abtc_instr_s instr, input wire logic [7:0] pc_high_buffer,
   input wire logic [7:0] table_high_pointer,
   input wire logic instr_ready, input wire logic [7:0] working_register,
   input wire logic zero_flag, input wire logic [9:0] pc, input wire logic [7:0] stack_pointer,
   input wire logic skip_pending, input wire abtc_pkg::abtc_reg_wr_s reg_wr,
   input wire abtc_pkg::abtc_stack_wr_s stack_wr
);
   import abtc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Taken and not discarded, by kind
   wire logic tk = instr_valid & instr_ready & !skip_pending;
   wire logic an = tk & (instr.op == OP_AND_IMMEDIATE);
   wire logic cl = tk & (instr.op inside {OP_DIRECT_CALL, OP_INDIRECT_CALL});
   sequence s_call; cl ##1 !instr_ready; endsequence
   // Execution checks
   and_value_a: assert property (an |=> working_register == ($past(working_register) &
      $past(instr.imm)) && zero_flag == (working_register == 8'h00)) else $error("and");
   flag_keep_a: assert property (instr_valid && instr_ready && !an |=> $stable(zero_flag))
      else $error("flag");
   bit_set_a: assert property (tk && instr.op == OP_BIT_SET |=> reg_wr.we &&
      reg_wr.addr == $past(instr.reg_addr) && reg_wr.data[$past(instr.bit_sel)]) else $error("set");
   set_only_a: assert property (tk && instr.op != OP_BIT_SET |=> !reg_wr.we) else $error("wr");
   call_push_a: assert property (cl |=> stack_wr.we && stack_wr.idx == $past(stack_pointer)
      && stack_wr.data == $past(pc) + PC_STEP) else $error("push");
   call_dead_a: assert property (s_call |=> instr_ready) else $error("dead");
   direct_pc_a: assert property (tk && instr.op == OP_DIRECT_CALL |=> pc ==
      {$past(pc_high_buffer[1:0]), $past(instr.imm)}) else $error("pc");
   indirect_pc_a: assert property (tk && instr.op == OP_INDIRECT_CALL |=> pc ==
      {$past(table_high_pointer[1:0]), $past(working_register)}) else $error("pca");
   skip_drop_a: assert property (instr_valid && instr_ready && skip_pending |=> !skip_pending
      && $stable(working_register)) else $error("skip");
endmodule : abtc_exec_assertions
bind abtc_exec abtc_exec_assertions abtc_exec_assertions_inst (.mclk, .rst_n, .instr_valid, .instr,
   .pc_high_buffer, .table_high_pointer, .instr_ready, .working_register, .zero_flag, .pc,
   .stack_pointer,
   .skip_pending, .reg_wr, .stack_wr);

// ===== tb/abtc_exec_tb.sv
`timescale 1ns/1ns
module abtc_exec_tb;
   import abtc_pkg::*;
   logic mclk = 0, rst_n = 0, instr_valid = 0, instr_ready, zero_flag, skip_pending;
   logic [7:0] pc_high_buffer = 0, table_high_pointer = 0, working_register, stack_pointer;
   logic [9:0] pc, p;
   abtc_instr_s instr = '0;
   abtc_reg_wr_s reg_wr;
   abtc_stack_wr_s stack_wr;
   int err_count = 0, samples_checked = 0;
   always #25 mclk = ~mclk;
   abtc_exec abtc_exec_inst (.*);
   abtc_stack_model abtc_stack_model_inst (.mclk, .stack_wr);
   // Compare and count
   task automatic chk(string n, logic [9:0] e, s);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Offer one instruction for one edge
   task automatic go(abtc_op_e o, logic [7:0] i, logic [5:0] a = 0, logic [2:0] b = 0);
      @(negedge mclk);
      instr_valid = 1;
      instr = '{o, a, b, i};
      @(negedge mclk);
      instr_valid = 0;
   endtask : go
   // AND with zero flag, then bit set read-modify-write on the top register
   task automatic t_alu;
      go(OP_LOAD_WORKING, 8'h5a);
      go(OP_AND_IMMEDIATE, 8'haf);
      chk("and", 10'h00a, {1'b0, zero_flag, working_register});
      go(OP_AND_IMMEDIATE, 8'h00);
      chk("zero", 10'h100, {1'b0, zero_flag, working_register});
      go(OP_BIT_SET, 0, 6'h3f, 3'h7);
      go(OP_BIT_SET, 0, 6'h3f, 3'h0);
      chk("set", 10'h081, {2'b00, reg_wr.data});
      $display("alu done");
   endtask : t_alu
   // Both skip forms; discarded loads must leave the working register alone
   task automatic t_skip;
      go(OP_SKIP_IF_CLEAR, 0, 6'h3f, 3'h7);
      go(OP_SKIP_IF_SET, 0, 6'h3f, 3'h7);
      go(OP_LOAD_WORKING, 8'h33);
      go(OP_SKIP_IF_CLEAR, 0, 6'h3f, 3'h3);
      go(OP_LOAD_WORKING, 8'h44);
      chk("skip", 10'h000, {2'b00, working_register});
      $display("skip done");
   endtask : t_skip
   // Direct then indirect call, the direct call's push lands in the stack
   task automatic t_call;
      pc_high_buffer = 8'hfe;
      table_high_pointer = 8'h02;
      go(OP_LOAD_WORKING, 8'h34);
      p = pc;
      go(OP_DIRECT_CALL, 8'h77);
      chk("pc", 10'h277, pc);
      go(OP_INDIRECT_CALL, 0);
      chk("pca", 10'h234, pc);
      chk("ret", p + 10'h001, abtc_stack_model_inst.mem[0]);
      chk("sp", 10'h002, {2'b00, stack_pointer});
      $display("call done");
   endtask : t_call
   // Counts and verdict
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      repeat (8) @(negedge mclk);
      rst_n = 1;
      t_alu;
      t_skip;
      t_call;
      test_done;
   end
   // Watchdog, many times the expected run
   initial begin
      #20000;
      err_count++;
      test_done;
   end
endmodule : abtc_exec_tb
